// file: verilog/cofz_pkg.sv
// Constants and types shared by the clock output freeze control block.
// Behaviour
// (RQ1) Serial mask holds thirteen output enable bits.
// (RQ2) Bus and peripheral clock zero unmasked.
// (RQ3) Mask zero freezes output, one lets run.
// (RQ4) Frozen output stays low, never toggles.
// (RQ5) Strobe with level low freezes all.
// (RQ6) Strobe with level high unfreezes all.
// (RQ7) Common freeze covers all fifteen outputs.
// (RQ8) Host sends low start, thirteen bits.
// (RQ9) Data sampled on serial clock rising edge.
// (RQ10) Mask bit order follows output list.
// (RQ11) Gate changes only while output low.
// (RQ12) Reset: mask all ones, outputs running.
package cofz_pkg;

	// Number of serially maskable outputs.
	localparam int MASK_W = 13;
	// Total number of clock outputs.
	localparam int OUT_N = 15;
	// Width of the serial bit counter.
	localparam int BIT_CNT_W = 4;
	// Mask value after reset: every output runs.
	localparam logic [MASK_W-1:0] MASK_RESET = 13'h1fff;
	// Level of the serial start bit.
	localparam logic START_LEVEL = 1'b0;

	// Output positions; positions below MASK_W match mask bits.
	localparam int IDX_DOUBLE_RATE_CPU_CLOCK = 0;
	localparam int IDX_CPU_CLOCK_ENABLE_OUT = 1;
	localparam int IDX_BUS_CLOCK_ENABLE_OUT = 2;
	localparam int IDX_BUS_CLOCK_FIRST = 3;
	localparam int IDX_PERIPH_CLOCK_FIRST = 7;
	localparam int IDX_BUS_CLOCK_ZERO_OUT = 13;
	localparam int IDX_PERIPHERAL_CLOCK_ZERO_OUT = 14;

	// Positions of the pins inside the synchroniser vector.
	localparam int PIN_N = 4;
	localparam int PIN_SER_CLK = 0;
	localparam int PIN_SER_DATA_N = 1;
	localparam int PIN_COMMON_N = 2;
	localparam int PIN_STROBE_N = 3;
	// Pin levels seen before the first sample.
	localparam logic [PIN_N-1:0] PIN_RESET = 4'he;

	// Serial receiver states.
	typedef enum logic {RX_IDLE, RX_DATA} cofz_rx_state_t;

endpackage

// file: verilog/cofz_mask_rx.sv
// Serial receiver that loads the output freeze mask.
module cofz_mask_rx
#(
	parameter int MASK_W = cofz_pkg::MASK_W,
	parameter int BIT_CNT_W = cofz_pkg::BIT_CNT_W
)
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// Synchronised serial port levels.
	input wire logic serClk,
	input wire logic serData,
	// Loaded mask and its load strobe.
	output logic [MASK_W-1:0] mask,
	output logic loadPulse
);
	import cofz_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Receiver state.
	cofz_rx_state_t state, next_state; // Idle or collecting bits.
	logic [BIT_CNT_W-1:0] bitCnt, next_bitCnt; // Next bit position.
	logic [MASK_W-1:0] shift, next_shift; // Bits collected so far.
	logic [MASK_W-1:0] next_mask; // Mask after this cycle.
	logic next_loadPulse; // High for the cycle after the last bit.
	logic prevClk; // Serial clock level one cycle ago.
	logic riseClk; // Rising edge of the serial clock.
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(MASK_W - 1);

	// Next state; bits land in a shadow and reach the mask together,
	// so the outputs never see a half loaded pattern.
	always_comb
	begin
		riseClk = serClk & ~prevClk;
		next_state = state;
		next_bitCnt = bitCnt;
		next_shift = shift;
		next_mask = mask;
		next_loadPulse = 1'b0;
		// (RQ9) rising edge sampling
		if (riseClk)
		begin
			unique case (state)
				RX_IDLE:
				begin
					// (RQ8) start bit detect
					if (serData == START_LEVEL)
					begin
						next_state = RX_DATA;
						next_bitCnt = '0;
					end
				end
				RX_DATA:
				begin
					// (RQ10) bit zero first
					next_shift[bitCnt] = serData;
					// (RQ1) thirteen bit load
					if (bitCnt == LAST_BIT)
					begin
						next_mask = next_shift;
						next_loadPulse = 1'b1;
						next_state = RX_IDLE;
					end
					else
					begin
						next_bitCnt = bitCnt + 1'b1;
					end
				end
			endcase
		end
	end

	// Registers; a low clock enable holds everything.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= RX_IDLE;
			bitCnt <= '0;
			shift <= '0;
			// (RQ12) mask resets to ones
			mask <= {MASK_W{1'b1}};
			loadPulse <= 1'b0;
			prevClk <= 1'b0;
		end
		else if (clkEn)
		begin
			state <= next_state;
			bitCnt <= next_bitCnt;
			shift <= next_shift;
			mask <= next_mask;
			loadPulse <= next_loadPulse;
			prevClk <= serClk;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks.
	property p_sample_bit;
		@(posedge clk) disable iff (rst)
		clkEn && state == RX_DATA && serClk && !prevClk
		|=> shift[$past(bitCnt)] == $past(serData);
	endproperty
	a_sample_bit: assert property (p_sample_bit) // (RQ9)
		else $error("serial bit not captured on clock rise");

	property p_load_last;
		@(posedge clk) disable iff (rst)
		clkEn && state == RX_DATA && serClk && !prevClk
		&& bitCnt == LAST_BIT |=> loadPulse && state == RX_IDLE
		&& mask == shift;
	endproperty
	a_load_last: assert property (p_load_last) // (RQ1)
		else $error("mask not loaded after last serial bit");

	property p_mask_hold;
		@(posedge clk) disable iff (rst)
		!loadPulse |-> $stable(mask) || $past(rst);
	endproperty
	a_mask_hold: assert property (p_mask_hold) // (RQ8)
		else $error("mask changed without a complete frame");

endmodule

// file: verilog/cofz_top.sv
// Output freeze control for a fifteen output clock driver.
module cofz_top
#(
	parameter int MASK_W = cofz_pkg::MASK_W,
	parameter int OUT_N = cofz_pkg::OUT_N
)
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// Control pins from the power management controller.
	input wire logic freezeClkPin,
	input wire logic freezeDataNPin,
	input wire logic commonFreezeNPin,
	input wire logic freezeStrobeNPin,
	// Running clocks from the internal dividers, same clock domain.
	input wire logic [cofz_pkg::OUT_N-1:0] runClk,
	// Gated clock outputs.
	output logic [cofz_pkg::OUT_N-1:0] clkOut
);
	import cofz_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// First stage; only the second stage reads it.
	logic [PIN_N-1:0] pinMeta;
	// Second stage; the only pin copy that logic may look at.
	logic [PIN_N-1:0] pinSync;
	// Next values of both stages.
	logic [PIN_N-1:0] next_pinMeta, next_pinSync;

	// The pins are asynchronous, so each passes two flip-flops first.
	// Latency is two cycles, well inside the serial clock period.
	always_comb
	begin
		next_pinMeta = {freezeStrobeNPin, commonFreezeNPin,
			freezeDataNPin, freezeClkPin};
		next_pinSync = pinMeta;
	end

	// Synchroniser registers, idle pin levels after reset.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pinMeta <= PIN_RESET;
			pinSync <= PIN_RESET;
		end
		else if (clkEn)
		begin
			pinMeta <= next_pinMeta;
			pinSync <= next_pinSync;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial mask port.

	// Currently loaded mask, one enable per maskable output.
	logic [MASK_W-1:0] mask;
	// Load strobe from the receiver; nothing in this module reads it.
	logic maskLoad;

	// The receiver holds the mask itself; the host may only write it.
	cofz_mask_rx #(
		.MASK_W(MASK_W),
		.BIT_CNT_W(BIT_CNT_W)
	) u_rx (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.serClk(pinSync[PIN_SER_CLK]),
		.serData(pinSync[PIN_SER_DATA_N]),
		.mask(mask),
		.loadPulse(maskLoad)
	);

	////////////////////////////////////////////////////////////////////
	// Common freeze through the strobe.

	// High while the common path lets all outputs run.
	logic commonRun, next_commonRun;
	// Strobe level one cycle ago, for falling edge detection.
	logic prevStrobe;
	// Falling edge of the strobe.
	logic strobeFall;

	// The level is taken on the strobe's falling edge, so a slow or
	// wandering level between strobes has no effect on the outputs.
	always_comb
	begin
		strobeFall = prevStrobe & ~pinSync[PIN_STROBE_N];
		next_commonRun = commonRun;
		// (RQ5) strobe latches freeze level
		if (strobeFall)
		begin
			// (RQ6) high level unfreezes all
			next_commonRun = pinSync[PIN_COMMON_N];
		end
	end

	// Common freeze registers; unfrozen after reset.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			// (RQ12) common path runs
			commonRun <= 1'b1;
			prevStrobe <= 1'b1;
		end
		else if (clkEn)
		begin
			commonRun <= next_commonRun;
			prevStrobe <= pinSync[PIN_STROBE_N];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per output gating.

	// Wanted run state of each output.
	logic [OUT_N-1:0] enable;
	// Gate state actually applied to each output.
	logic [OUT_N-1:0] gate;
	// Gate state as it stands in this cycle.
	logic [OUT_N-1:0] gateNow;
	// Next output levels.
	logic [OUT_N-1:0] next_clkOut;

	// One slice per output. The gate may only follow its enable while
	// the running clock is low, which keeps every pulse full width.
	// The price is up to half a divider period of extra freeze delay.
	genvar k;
	generate
		for (k = 0; k < OUT_N; k++)
		begin : g_out
			if (k < MASK_W)
			begin : g_masked
				// (RQ3) mask one runs output
				assign enable[k] = mask[k] & commonRun;
			end
			else
			begin : g_free
				// (RQ2) no mask bit here
				// (RQ7) common freeze still applies
				assign enable[k] = commonRun;
			end
			// (RQ11) change only while low
			assign gateNow[k] = runClk[k] ? gate[k] : enable[k];
			// (RQ4) frozen output held low
			assign next_clkOut[k] = runClk[k] & gateNow[k];
		end
	endgenerate

	// Gate and output registers; outputs come straight from flops.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate <= '1;
			clkOut <= '0;
		end
		else if (clkEn)
		begin
			gate <= gateNow;
			clkOut <= next_clkOut;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks.

	property p_frozen_low;
		@(posedge clk) disable iff (rst)
		clkEn |=> (clkOut & ~$past(gateNow)) == '0;
	endproperty
	a_frozen_low: assert property (p_frozen_low) // (RQ4)
		else $error("frozen output not held low");

	property p_no_runt;
		@(posedge clk) disable iff (rst)
		clkEn |=> ((gate ^ $past(gate)) & $past(runClk)) == '0;
	endproperty
	a_no_runt: assert property (p_no_runt) // (RQ11)
		else $error("gate changed while its clock was high");

	// The strobe with a low level must clear the common run state.
	property p_strobe_freeze;
		@(posedge clk) disable iff (rst)
		clkEn && strobeFall && !pinSync[PIN_COMMON_N] |=> !commonRun;
	endproperty
	a_strobe_freeze: assert property (p_strobe_freeze) // (RQ5)
		else $error("strobe with low level did not freeze all");

	// While frozen in common, a cycle with every clock low closes
	// every gate at once; this happens often, so the check is live.
	property p_freeze_all;
		@(posedge clk) disable iff (rst)
		clkEn && !commonRun && runClk == '0
		|=> gate == '0 && clkOut == '0;
	endproperty
	a_freeze_all: assert property (p_freeze_all) // (RQ5)
		else $error("common freeze left an output running");

	property p_strobe_run;
		@(posedge clk) disable iff (rst)
		clkEn && strobeFall && pinSync[PIN_COMMON_N] |=> commonRun;
	endproperty
	a_strobe_run: assert property (p_strobe_run) // (RQ6)
		else $error("strobe with high level did not unfreeze");

	property p_common_all;
		@(posedge clk) disable iff (rst)
		clkEn && !commonRun && !runClk[IDX_BUS_CLOCK_ZERO_OUT]
		&& !runClk[IDX_PERIPHERAL_CLOCK_ZERO_OUT]
		|=> !gate[IDX_BUS_CLOCK_ZERO_OUT]
		&& !gate[IDX_PERIPHERAL_CLOCK_ZERO_OUT];
	endproperty
	a_common_all: assert property (p_common_all) // (RQ7)
		else $error("common freeze missed an unmasked output");

	property p_unmasked_run;
		@(posedge clk) disable iff (rst)
		clkEn && commonRun && mask == '0 && !runClk[IDX_BUS_CLOCK_ZERO_OUT]
		|=> gate[IDX_BUS_CLOCK_ZERO_OUT];
	endproperty
	a_unmasked_run: assert property (p_unmasked_run) // (RQ2)
		else $error("bus clock zero stopped by the mask");

	property p_mask_zero;
		@(posedge clk) disable iff (rst)
		clkEn |=> (~$past(mask) & ~$past(runClk[MASK_W-1:0])
		& gate[MASK_W-1:0]) == '0;
	endproperty
	a_mask_zero: assert property (p_mask_zero) // (RQ3)
		else $error("mask zero did not freeze its output");

	property p_mask_bit_map;
		@(posedge clk) disable iff (rst)
		clkEn && commonRun && mask[IDX_PERIPH_CLOCK_FIRST]
		&& !runClk[IDX_PERIPH_CLOCK_FIRST]
		|=> gate[IDX_PERIPH_CLOCK_FIRST];
	endproperty
	a_mask_bit_map: assert property (p_mask_bit_map) // (RQ10)
		else $error("mask bit steered the wrong output");

	property p_reset_state;
		@(posedge clk) disable iff (rst)
		$past(rst) |-> mask == MASK_RESET && commonRun && gate == '1;
	endproperty
	a_reset_state: assert property (p_reset_state) // (RQ12)
		else $error("state after reset is not all running");

endmodule

// file: tb/cofz_ctrl_model.sv
// Behavioural model of the controller that drives the freeze pins.
module cofz_ctrl_model
(
	// Bench clock.
	input wire logic clk,
	// Freeze pins towards the block.
	output logic serClk,
	output logic serDataN,
	output logic levelN,
	output logic strobeN
);
	timeunit 1ns;
	timeprecision 1ns;
	import cofz_pkg::*;

	// Divider for the free running serial clock, 800 ns period.
	logic [1:0] div;

	// Data, level and strobe pins idle high, as their pull-ups would leave them; the serial clock starts low.
	initial
	begin
		serClk = 1'b0;
		serDataN = 1'b1;
		levelN = 1'b1;
		strobeN = 1'b1;
		div = 2'h0;
	end

	// The serial clock runs free, also between frames.
	always @(posedge clk)
	begin
		div <= div + 2'h1;
		if (div == 2'h3)
			serClk <= ~serClk;
	end

	////////////////////////////////////////////////////////////////////////
	// Sends one frame and leaves the data line at its last bit.
	task automatic sendFrame(input logic [MASK_W-1:0] m);
		logic [MASK_W:0] bits;
		bits = {m, START_LEVEL};
		for (int b = 0; b <= MASK_W; b++)
		begin
			// change at fall, stable at rise.
			@(negedge serClk);
			serDataN <= bits[b];
		end
	endtask

	// Sends a frame, then returns the data line high.
	task automatic sendMask(input logic [MASK_W-1:0] m);
		sendFrame(m);
		@(negedge serClk);
		serDataN <= 1'b1;
	endtask

	// Sets the common level without a strobe; the block must ignore it.
	task automatic setLevel(input logic level);
		@(posedge clk);
		levelN <= level;
	endtask

	// The level is set up well before the fall, so it is taken cleanly.
	task automatic strobe(input logic level);
		setLevel(level);
		repeat (4) @(posedge clk);
		strobeN <= 1'b0;
		repeat (3) @(posedge clk);
		strobeN <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule

// file: tb/test_clock_output_freeze_control.sv
// Self-checking bench for the clock output freeze control block.
`define CHK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			failCount++; \
			$display("BAD %s exp %h got %h", nm, e, g); \
		end \
	end

module test_clock_output_freeze_control;
	timeunit 1ns;
	timeprecision 1ns;
	import cofz_pkg::*;

	// Clock, reset and design pins.
	logic clk;
	logic rst;
	logic clkEn;
	logic [OUT_N-1:0] runClk;
	logic [OUT_N-1:0] clkOut;
	logic serClk;
	logic serDataN;
	logic levelN;
	logic strobeN;
	// Divider counter that makes runs of period 2, 4 and 8 cycles.
	logic [2:0] cnt;
	// Expected gate vectors, oldest first.
	logic [OUT_N-1:0] expQ[$];
	logic [OUT_N-1:0] cur;
	logic [OUT_N-1:0] runPrev;
	logic [MASK_W-1:0] curMask;
	logic [MASK_W-1:0] m;
	logic comRun;
	int winCnt;
	int failCount;
	int checked;
	int cycles;

	cofz_top cofz_top_inst (.clk(clk), .rst(rst), .clkEn(clkEn),
		.freezeClkPin(serClk), .freezeDataNPin(serDataN),
		.commonFreezeNPin(levelN), .freezeStrobeNPin(strobeN),
		.runClk(runClk), .clkOut(clkOut));

	cofz_ctrl_model cofz_ctrl_model_inst (.clk(clk), .serClk(serClk),
		.serDataN(serDataN), .levelN(levelN), .strobeN(strobeN));

	// Free running bench clock, 100 ns period.
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Divider runs; mixed rates make the low-phase wait differ per output.
	always @(posedge clk)
	begin
		cnt <= cnt + 3'h1;
		for (int i = 0; i < OUT_N; i++)
			runClk[i] <= cnt[i % 3];
	end

	////////////////////////////////////////////////////////////////////////
	// Watcher: a note opens a window where every cycle is compared.
	always @(posedge clk)
	begin
		if (winCnt == 0 && expQ.size() > 0)
		begin
			cur = expQ.pop_front();
			winCnt = 16;
		end
		if (winCnt > 0)
		begin
			`CHK("clkOut", runPrev & cur, clkOut)
			winCnt--;
		end
		runPrev = runClk;
	end

	// A hang is cut short well beyond the expected run length.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failCount++;
			endSim();
		end
	end

	// Prints the verdict and stops the run.
	task automatic endSim();
		if (failCount == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Lets the gates settle, notes the expectation, then waits out its window.
	task automatic check();
		repeat (20) @(posedge clk);
		expQ.push_back({2'b11, curMask} & {OUT_N{comRun}});
		repeat (18) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		rst = 1'b1;
		clkEn = 1'b1;
		cnt = 3'h0;
		runClk = '0;
		winCnt = 0;
		failCount = 0;
		checked = 0;
		cycles = 0;
		curMask = '1;
		comRun = 1'b1;
		void'($urandom(32'hf82c));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		check();
		// Zero mask first: only the two unmaskable outputs may keep running.
		for (int k = 0; k < 5; k++)
		begin
			m = (k == 0) ? '0 : MASK_W'($urandom);
			cofz_ctrl_model_inst.sendMask(m);
			curMask = m;
			check();
		end
		cofz_ctrl_model_inst.strobe(1'b0);
		comRun = 1'b0;
		check();
		// A level change without a strobe must change nothing.
		cofz_ctrl_model_inst.setLevel(1'b1);
		check();
		// Two frames back to back while frozen; the last one stands.
		cofz_ctrl_model_inst.sendFrame(MASK_W'($urandom));
		m = MASK_W'($urandom);
		cofz_ctrl_model_inst.sendMask(m);
		curMask = m;
		check();
		cofz_ctrl_model_inst.strobe(1'b1);
		comRun = 1'b1;
		check();
		// A low clock enable freezes the pins too, so this strobe is lost.
		clkEn <= 1'b0;
		cofz_ctrl_model_inst.strobe(1'b0);
		clkEn <= 1'b1;
		check();
		// A second reset in mid-run, while frozen, must open every gate.
		cofz_ctrl_model_inst.strobe(1'b0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		curMask = '1;
		comRun = 1'b1;
		check();
		endSim();
	end
endmodule
